// *** gpt_timers.sv ***
// three general purpose delay timers behind an apb register slave
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpt_timers #(
  parameter int TICK_CYCLES = gpt_pkg::TICK_CYCLES // cycles per second
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [7:0] term_in, // digital terminal inputs
  input wire logic [7:0] cmp_flag, // analogue comparison flags
  input wire logic [15:0] logic_in, // other internal signals
  output logic [gpt_pkg::NUM_TIMERS-1:0] timer_out // timer results
);
  import gpt_pkg::*;

  logic [NUM_SRC-1:0] sources;
  logic [IVL_W-1:0] interval [NUM_TIMERS];
  logic [1:0] mode [NUM_TIMERS];
  logic [SEL_W-1:0] sel1 [NUM_TIMERS];
  logic [SEL_W-1:0] sel2 [NUM_TIMERS];
  logic [SEL_W-1:0] selr [NUM_TIMERS];
  logic [7:0] timing_table [NUM_TIMERS];
  logic [7:0] reset_table [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] timing_sig;
  logic [NUM_TIMERS-1:0] reset_sig;
  logic [IVL_W-1:0] elapsed [NUM_TIMERS];
  logic [3:0] state_bits [NUM_TIMERS];
  logic [31:0] next_rdata;
  logic [7:0] ofs;
  logic [1:0] sel_tmr;
  logic tmr_hit;
  logic addr_ok;
  logic wr_en;

  // source vector: terminals low, then flags, then internal logic
  assign sources = {logic_in, cmp_flag, term_in};

  // zero wait states; decode errors only flagged in the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && tmr_hit;

  // word offset inside a timer block
  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    word_ofs = {4'h0, a[3:0]};
  endfunction

  // is this an aligned address inside the timer blocks
  function automatic logic in_timers(input logic [7:0] a);
    in_timers = (a < TMR_SPAN) && (a[1:0] == 2'h0);
  endfunction

  // address decode
  always_comb
  begin
    ofs = word_ofs(paddr);
    sel_tmr = paddr[5:4];
    tmr_hit = in_timers(paddr);
    if (tmr_hit)
      addr_ok = 1'b1;
    else if (paddr == OFS_SRC_VIEW)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  end

  // configuration registers; status and source view ignore writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        interval[i] <= INTERVAL_RST;
        mode[i] <= MODE_RST;
        sel1[i] <= SEL_RST;
        sel2[i] <= SEL_RST;
        selr[i] <= SEL_RST;
        timing_table[i] <= TABLE_RST;
        reset_table[i] <= TABLE_RST;
      end
    end
    else if (wr_en)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (sel_tmr == 2'(i))
        begin
          if (ofs == OFS_INTERVAL)
            interval[i] <= pwdata[IVL_W-1:0];
          else if (ofs == OFS_CTRL)
          begin
            mode[i] <= pwdata[CTRL_MODE_LSB +: 2];
            sel1[i] <= pwdata[CTRL_SEL1_LSB +: SEL_W];
            sel2[i] <= pwdata[CTRL_SEL2_LSB +: SEL_W];
            selr[i] <= pwdata[CTRL_SELR_LSB +: SEL_W];
          end
          else if (ofs == OFS_LOGIC)
          begin
            timing_table[i] <= pwdata[7:0];
            reset_table[i] <= pwdata[LOGIC_RST_LSB +: 8];
          end
        end
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (paddr == OFS_SRC_VIEW)
      next_rdata = sources;
    else if (tmr_hit && sel_tmr != 2'h3)
    begin
      if (ofs == OFS_INTERVAL)
        next_rdata[IVL_W-1:0] = interval[sel_tmr];
      else if (ofs == OFS_CTRL)
      begin
        next_rdata[CTRL_MODE_LSB +: 2] = mode[sel_tmr];
        next_rdata[CTRL_SEL1_LSB +: SEL_W] = sel1[sel_tmr];
        next_rdata[CTRL_SEL2_LSB +: SEL_W] = sel2[sel_tmr];
        next_rdata[CTRL_SELR_LSB +: SEL_W] = selr[sel_tmr];
      end
      else if (ofs == OFS_LOGIC)
      begin
        next_rdata[7:0] = timing_table[sel_tmr];
        next_rdata[LOGIC_RST_LSB +: 8] = reset_table[sel_tmr];
      end
      else if (ofs == OFS_STATUS)
      begin
        next_rdata[0] = timer_out[sel_tmr];
        next_rdata[1] = timing_sig[sel_tmr];
        next_rdata[2] = reset_sig[sel_tmr];
        next_rdata[STAT_STATE_LSB +: 4] = state_bits[sel_tmr];
        next_rdata[STAT_CNT_LSB +: IVL_W] = elapsed[sel_tmr];
      end
    end
  end

  // read data captured in the setup cycle, valid through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_rdata;
  end

  // three identical timers, each with private settings
  for (genvar g = 0; g < NUM_TIMERS; g++)
  begin : g_tmr
    gpt_input_logic u_logic (
      .pclk(pclk),
      .presetn(presetn),
      .sources(sources),
      .sel1(sel1[g]),
      .sel2(sel2[g]),
      .selr(selr[g]),
      .timing_table(timing_table[g]),
      .reset_table(reset_table[g]),
      .timing_out(timing_sig[g]),
      .reset_out(reset_sig[g])
    );

    gpt_channel #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .mode(mode[g]),
      .interval(interval[g]),
      .timing_in(timing_sig[g]),
      .reset_in(reset_sig[g]),
      .timer_out(timer_out[g]),
      .elapsed(elapsed[g]),
      .state_bits(state_bits[g])
    );

    // index of the term the sources point at this cycle
    logic [2:0] term_now;
    assign term_now = {sources[sel1[g]], sources[sel2[g]],
                       sources[selr[g]]};

    term_select_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        $stable(timing_table[g]) && $stable(term_now)
        |-> timing_sig[g] == timing_table[g][$past(term_now)])
      else $error("timing table output mismatch");

    reset_table_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        ##1 reset_sig[g] == $past(reset_table[g][term_now]))
      else $error("reset table output mismatch");

    source_msb_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (timing_table[g] == 8'hF0) && $stable(timing_table[g])
        |=> timing_sig[g] == $past(sources[sel1[g]]))
      else $error("first timing source not msb");

    on_fall_now_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_ON) && timer_out[g] && !timing_sig[g]
        |=> !timer_out[g])
      else $error("delay-on output did not fall at once");

    on_rise_cause_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_ON) && $rose(timer_out[g])
        |-> $past(timing_sig[g]) && !$past(reset_sig[g]))
      else $error("delay-on output rose without timing input");

    on_wait_full_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_ON) && $rose(timer_out[g])
        && $stable(interval[g]) && interval[g] != INTERVAL_RST
        |-> $past(elapsed[g]) >= interval[g])
      else $error("delay-on output rose before interval");

    init_bypass_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_ON_INIT) && reset_sig[g] && timing_sig[g]
        |=> timer_out[g])
      else $error("init mode did not bypass timing on reset");

    off_rise_now_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_OFF) && timing_sig[g] |=> timer_out[g])
      else $error("delay-off output did not rise at once");

    off_fall_cause_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_OFF) && $fell(timer_out[g])
        |-> !$past(timing_sig[g]))
      else $error("delay-off output fell with timing input high");

    off_wait_full_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        (mode[g] == MODE_OFF) && $fell(timer_out[g])
        && $stable(interval[g]) && interval[g] != INTERVAL_RST
        && !$past(reset_sig[g])
        |-> $past(elapsed[g]) >= interval[g])
      else $error("delay-off output fell before interval");

    count_clear_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        reset_sig[g] |=> elapsed[g] == INTERVAL_RST)
      else $error("reset output did not clear the count");

    count_step_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        $changed(elapsed[g]) |-> elapsed[g] == INTERVAL_RST
        || elapsed[g] == $past(elapsed[g]) + 16'h0001)
      else $error("second count jumped");

    interval_write_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_tmr == 2'(g) && ofs == OFS_INTERVAL
        |=> interval[g] == $past(pwdata[IVL_W-1:0]))
      else $error("interval write did not land");

    table_write_a:
      assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_tmr == 2'(g) && ofs == OFS_LOGIC
        |=> reset_table[g] == $past(pwdata[LOGIC_RST_LSB +: 8]))
      else $error("reset table write did not land");
  end

  // an unmapped transfer is answered with an error in its first access cycle
  apb_error_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !addr_ok |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // read data must not move while the master may still sample it
  read_hold_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data moved in access phase");

  // error is only ever shown in the access phase
  error_phase_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> psel && penable)
    else $error("error flagged outside access phase");
endmodule
`default_nettype wire

// *** gpt_pkg.sv ***
// constants and types shared by the general purpose delay timers
package gpt_pkg;
  // system clock and the one-second interval unit
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  // structure
  localparam int NUM_TIMERS = 3;
  localparam int NUM_SRC = 32;
  localparam int SEL_W = 5;
  localparam int IVL_W = 16;
  // register offsets, per timer block and global
  localparam logic [7:0] TMR_SPAN = 8'h30;
  localparam logic [7:0] OFS_INTERVAL = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_LOGIC = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_SRC_VIEW = 8'h30;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL1_LSB = 8;
  localparam int CTRL_SEL2_LSB = 16;
  localparam int CTRL_SELR_LSB = 24;
  localparam int LOGIC_RST_LSB = 8;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_CNT_LSB = 16;
  // values after reset
  localparam logic [IVL_W-1:0] INTERVAL_RST = 16'h0000;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic [7:0] TABLE_RST = 8'h00;
  // timer functions
  typedef enum logic [1:0] {
    MODE_ON = 2'h0,
    MODE_ON_INIT = 2'h1,
    MODE_OFF = 2'h2
  } gpt_mode_t;
  // one-hot timer states
  typedef enum logic [3:0] {
    ST_LOW = 4'h1,
    ST_TIMING_ON = 4'h2,
    ST_HIGH = 4'h4,
    ST_TIMING_OFF = 4'h8
  } gpt_state_t;
endpackage

// *** gpt_input_logic.sv ***
// source selection and the two truth tables of one timer
`timescale 1ns/1ps
`default_nettype none
module gpt_input_logic (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [gpt_pkg::NUM_SRC-1:0] sources, // all digital sources
  input wire logic [gpt_pkg::SEL_W-1:0] sel1, // first timing source
  input wire logic [gpt_pkg::SEL_W-1:0] sel2, // second timing source
  input wire logic [gpt_pkg::SEL_W-1:0] selr, // reset source
  input wire logic [7:0] timing_table, // term bits for timing
  input wire logic [7:0] reset_table, // term bits for reset
  output logic timing_out, // drives interval logic
  output logic reset_out // drives timer reset
);
  import gpt_pkg::*;

  logic [2:0] term;

  function automatic logic pick(input logic [NUM_SRC-1:0] src,
                                input logic [SEL_W-1:0] sel);
    pick = src[sel];
  endfunction

  function automatic logic lookup(input logic [7:0] tbl,
                                  input logic [2:0] idx);
    lookup = tbl[idx];
  endfunction

  // first timing source is the msb, reset source the lsb
  assign term = {pick(sources, sel1), pick(sources, sel2),
                 pick(sources, selr)};

  // registered so both tables see the same sampled term
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timing_out <= 1'b0;
      reset_out <= 1'b0;
    end
    else
    begin
      timing_out <= lookup(timing_table, term);
      reset_out <= lookup(reset_table, term);
    end
  end
endmodule
`default_nettype wire

// *** gpt_channel.sv ***
// interval timing state machine of one timer
`timescale 1ns/1ps
`default_nettype none
module gpt_channel #(
  parameter int TICK_CYCLES = gpt_pkg::TICK_CYCLES // cycles per second
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [1:0] mode, // timer function
  input wire logic [gpt_pkg::IVL_W-1:0] interval, // seconds
  input wire logic timing_in, // timing table output
  input wire logic reset_in, // reset table output
  output logic timer_out, // timer result
  output logic [gpt_pkg::IVL_W-1:0] elapsed, // seconds counted
  output logic [3:0] state_bits // one-hot state
);
  import gpt_pkg::*;

  gpt_state_t state, next_state;
  logic [31:0] sub_cnt;
  logic first;
  logic phase;
  logic done;
  logic is_off;
  logic is_init;

  assign is_off = (mode == MODE_OFF);
  assign is_init = (mode == MODE_ON_INIT);
  assign phase = (state == ST_TIMING_ON) || (state == ST_TIMING_OFF);
  assign done = (elapsed >= interval);
  assign timer_out = (state == ST_HIGH) || (state == ST_TIMING_OFF);
  assign state_bits = state;

  // power-up window lasts until the timing signal is first seen low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first <= 1'b1;
    else if (!timing_in)
      first <= 1'b0;
  end

  // counting restarts with each phase so delays are whole seconds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sub_cnt <= 32'h0000_0000;
      elapsed <= INTERVAL_RST;
    end
    else if (reset_in || !phase || next_state != state)
    begin
      sub_cnt <= 32'h0000_0000;
      elapsed <= INTERVAL_RST;
    end
    else if (sub_cnt == 32'(TICK_CYCLES - 1))
    begin
      sub_cnt <= 32'h0000_0000;
      elapsed <= elapsed + 16'h0001;
    end
    else
      sub_cnt <= sub_cnt + 32'h0000_0001;
  end

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_LOW:
        // delay-off rises with its timing input even under reset
        if (reset_in)
          next_state = (timing_in && (is_init || is_off)) ?
                       ST_HIGH : ST_LOW;
        else if (timing_in)
        begin
          if (is_off || (is_init && first) || interval == INTERVAL_RST)
            next_state = ST_HIGH;
          else
            next_state = ST_TIMING_ON;
        end
      ST_TIMING_ON:
        if (reset_in)
          next_state = (is_init && timing_in) ? ST_HIGH : ST_LOW;
        else if (!timing_in)
          next_state = ST_LOW;
        else if (done)
          next_state = ST_HIGH;
      ST_HIGH:
        if (is_off)
        begin
          if (!timing_in)
            next_state = (reset_in || interval == INTERVAL_RST) ?
                         ST_LOW : ST_TIMING_OFF;
        end
        else if (!timing_in || (reset_in && !is_init))
          next_state = ST_LOW;
      ST_TIMING_OFF:
        if (timing_in)
          next_state = ST_HIGH;
        else if (reset_in || done)
          next_state = ST_LOW;
      default:
        next_state = ST_LOW;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_LOW;
    else
      state <= next_state;
  end
endmodule
`default_nettype wire

// *** gpt_src_model.sv ***
// behavioural model of the drive's internal digital sources
`timescale 1ns/1ps
`default_nettype none
module gpt_src_model (
  input wire logic presetn, // async reset, active low
  input wire logic [31:0] want, // source levels asked by the bench
  output logic [7:0] term_in, // digital terminal inputs
  output logic [7:0] cmp_flag, // analogue comparison flags
  output logic [15:0] logic_in // other internal signals
);
  // sources sit low while the drive is held in reset
  always_comb
  begin
    term_in = presetn ? want[7:0] : 8'h00;
    cmp_flag = presetn ? want[15:8] : 8'h00;
    logic_in = presetn ? want[31:16] : 16'h0000;
  end
endmodule
`default_nettype wire

// *** gpt_tb.sv ***
// self-checking testbench of the delay timers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpt_pkg::*;
  localparam int TK = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] want = 32'h0000_0000;
  logic [7:0] term_in;
  logic [7:0] cmp_flag;
  logic [15:0] logic_in;
  logic [NUM_TIMERS-1:0] timer_out;
  logic [31:0] q;
  logic err;
  int miscompares = 0;
  int check_count = 0;

  always #25 pclk = ~pclk;

  gpt_timers #(.TICK_CYCLES(TK)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .cmp_flag(cmp_flag), .logic_in(logic_in),
    .timer_out(timer_out)
  );

  gpt_src_model src (
    .presetn(presetn), .want(want), .term_in(term_in),
    .cmp_flag(cmp_flag), .logic_in(logic_in)
  );

  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        if (n == 20)
        begin
          miscompares++;
          conclude();
        end
        n++;
        @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // let n edges pass, then look once the updates have landed
  task waitn(input int n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask

  // configure one timer: interval, mode, three selects, two tables
  task setup(input int t, input logic [15:0] ivl, input logic [1:0] md,
             input logic [4:0] s1, input logic [4:0] s2,
             input logic [4:0] sr, input logic [7:0] tt,
             input logic [7:0] rt);
    logic [7:0] b;
    begin
      b = 8'(t * 16);
      apb(1'b1, b + OFS_INTERVAL, {16'h0000, ivl});
      apb(1'b1, b + OFS_CTRL, {3'h0, sr, 3'h0, s2, 3'h0, s1, 6'h00, md});
      apb(1'b1, b + OFS_LOGIC, {16'h0000, rt, tt});
      apb(1'b0, b + OFS_CTRL, 32'h0000_0000);
      check("ctrl", q, {3'h0, sr, 3'h0, s2, 3'h0, s1, 6'h00, md});
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end

  initial
  begin
    logic [7:0] tt;
    logic [7:0] rt;
    tt = 8'hA6;
    rt = 8'h5C;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of every timer's settings
    for (int t = 0; t < NUM_TIMERS; t++)
      for (int o = 0; o < 12; o += 4)
      begin
        apb(1'b0, 8'(t * 16 + o), 32'h0000_0000);
        check("reset value", q, 32'h0000_0000);
      end
    apb(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped err", {31'h0, err}, 32'h0000_0001);
    check("unmapped data", q, 32'h0000_0000);
    // timer 0: walk all eight terms of both tables
    setup(0, 16'h0000, 2'h0, 5'h00, 5'h01, 5'h02, tt, rt);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      want <= {29'h0, i[0], i[1], i[2]};
      waitn(3);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("timing term", {31'h0, q[1]}, {31'h0, tt[i]});
      check("reset term", {31'h0, q[2]}, {31'h0, rt[i]});
      check("no delay", {31'h0, q[0]}, {31'h0, tt[i] & ~rt[i]});
      apb(1'b0, OFS_SRC_VIEW, 32'h0000_0000);
      check("source view", q, {29'h0, i[0], i[1], i[2]});
    end
    // timer 1 delay-on, two seconds, reset on source 16
    setup(1, 16'h0002, 2'h0, 5'h08, 5'h09, 5'h10, 8'hF0, 8'hAA);
    @(posedge pclk);
    want[8] <= 1'b1;
    waitn(10);
    check("on early", {31'h0, timer_out[1]}, 32'h0000_0000);
    waitn(1);
    check("on late", {31'h0, timer_out[1]}, 32'h0000_0001);
    @(posedge pclk);
    want[16] <= 1'b1;
    waitn(3);
    check("on reset", {31'h0, timer_out[1]}, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check("elapsed clr", {16'h0, q[31:16]}, 32'h0000_0000);
    @(posedge pclk);
    want[16] <= 1'b0;
    waitn(10);
    check("restart", {31'h0, timer_out[1]}, 32'h0000_0000);
    waitn(1);
    check("rearmed", {31'h0, timer_out[1]}, 32'h0000_0001);
    @(posedge pclk);
    want[8] <= 1'b0;
    waitn(3);
    check("on fall", {31'h0, timer_out[1]}, 32'h0000_0000);
    // timer 1 init mode: reset true skips the timing phase
    setup(1, 16'h0002, 2'h1, 5'h08, 5'h09, 5'h10, 8'hF0, 8'hAA);
    @(posedge pclk);
    want[16] <= 1'b1;
    want[8] <= 1'b1;
    waitn(4);
    check("init bypass", {31'h0, timer_out[1]}, 32'h0000_0001);
    @(posedge pclk);
    want[8] <= 1'b0;
    waitn(3);
    check("init fall", {31'h0, timer_out[1]}, 32'h0000_0000);
    // timer 2 delay-off, one second
    setup(2, 16'h0001, 2'h2, 5'h18, 5'h19, 5'h1A, 8'hF0, 8'h00);
    @(posedge pclk);
    want[24] <= 1'b1;
    waitn(3);
    check("off rise", {31'h0, timer_out[2]}, 32'h0000_0001);
    @(posedge pclk);
    want[24] <= 1'b0;
    waitn(6);
    check("off hold", {31'h0, timer_out[2]}, 32'h0000_0001);
    waitn(1);
    check("off fall", {31'h0, timer_out[2]}, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
